// file: logic/timer_gate_single_pulse_control.sv
//
// Overview of operation
// - Single-pulse disabled leaves gate uncontrolled by it
// - Arm/status reads 1 while waiting
// - Arm/status reads 0 when idle or done
// - Clearing single-pulse enable clears arm/status
// - Gate falling edge clears arm, stops counting
// - Falling edge of the level seen by the counter sets sticky event flag
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module timer_gate_single_pulse_control (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  gate_source,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    output logic             count_enable,
    output logic             irq
);

    typedef struct packed {
        logic                                gate_function_enable;
        logic                                gate_polarity_select;
        logic                                gate_toggle_enable;
        logic                                gate_single_pulse_enable;
        logic                                gate_pulse_arm_status;
        logic                                gate_current_level;
        logic [1:0]                          gate_source_select;
        logic                                timer_run_enable;
        logic                                gate_event_flag;
        logic                                gate_event_mask;
        timer_gate_pkg::single_pulse_state_t sp_state;
        logic                                pready;
        logic [31:0]                         prdata;
        logic                                pslverr;
        logic                                count_enable;
        logic                                irq;
    } control_state_t;

    control_state_t state;
    control_state_t next_state;

    logic gate_level;
    logic gate_rise;
    logic gate_fall;

    // Source mux, polarity and toggle flip-flop
    gate_conditioner u_conditioner (
        .pclk          (pclk),
        .presetn       (presetn),
        .gate_source   (gate_source),
        .source_select (state.gate_source_select),
        .polarity_high (state.gate_polarity_select),
        .toggle_enable (state.gate_toggle_enable),
        .gate_level    (gate_level)
    );

    level_edge_detect u_gate_edges (
        .pclk    (pclk),
        .presetn (presetn),
        .level   (gate_level),
        .rise    (gate_rise),
        .fall    (gate_fall)
    );

    function automatic logic addr_mapped(input logic [11:0] addr);
        addr_mapped = (addr == timer_gate_pkg::ADDR_GATE_CONTROL) ||
                      (addr == timer_gate_pkg::ADDR_RUN_CONTROL)  ||
                      (addr == timer_gate_pkg::ADDR_IRQ_STATUS)   ||
                      (addr == timer_gate_pkg::ADDR_IRQ_MASK);
    endfunction

    function automatic logic [31:0] read_value(input logic [11:0] addr,
                                               input control_state_t s);
        logic [31:0] v;
        v = 32'h00000000;
        case (addr)
            timer_gate_pkg::ADDR_GATE_CONTROL: begin
                v[timer_gate_pkg::GATE_FUNCTION_ENABLE_BIT] = s.gate_function_enable;
                v[timer_gate_pkg::GATE_POLARITY_BIT]        = s.gate_polarity_select;
                v[timer_gate_pkg::GATE_TOGGLE_BIT]          = s.gate_toggle_enable;
                v[timer_gate_pkg::GATE_SINGLE_PULSE_BIT]    = s.gate_single_pulse_enable;
                v[timer_gate_pkg::GATE_ARM_STATUS_BIT]      = s.gate_pulse_arm_status;
                v[timer_gate_pkg::GATE_LEVEL_BIT]           = s.gate_current_level;
                v[timer_gate_pkg::GATE_SOURCE_LSB +: timer_gate_pkg::GATE_SOURCE_WIDTH] =
                    s.gate_source_select;
            end
            timer_gate_pkg::ADDR_RUN_CONTROL: begin
                v[timer_gate_pkg::RUN_ENABLE_BIT] = s.timer_run_enable;
            end
            timer_gate_pkg::ADDR_IRQ_STATUS: begin
                v[timer_gate_pkg::GATE_EVENT_BIT] = s.gate_event_flag;
            end
            timer_gate_pkg::ADDR_IRQ_MASK: begin
                v[timer_gate_pkg::GATE_EVENT_BIT] = s.gate_event_mask;
            end
            default: begin
                v = 32'h00000000;
            end
        endcase
        read_value = v;
    endfunction

    always_comb begin
        logic access_done;
        logic wr;
        logic rd;
        logic pulse_done;
        logic level_now;
        logic level_fall;
        access_done = 1'b0;
        wr          = 1'b0;
        rd          = 1'b0;
        pulse_done  = 1'b0;
        level_now   = 1'b0;
        level_fall  = 1'b0;
        next_state  = state;

        // One wait state: pready rises in the second access cycle
        access_done = psel && penable && state.pready;
        wr = access_done && pwrite && addr_mapped(paddr);
        rd = access_done && !pwrite && addr_mapped(paddr);

        next_state.pready  = psel && penable && !state.pready;
        next_state.pslverr = psel && penable && !state.pready && !addr_mapped(paddr);
        if (psel && penable && !state.pready && !pwrite) begin
            next_state.prdata = read_value(paddr, state);
        end else if (!psel) begin
            next_state.prdata = 32'h00000000;
        end

        // Single-pulse sequencer
        case (state.sp_state)
            timer_gate_pkg::SP_IDLE: begin
                if (state.gate_pulse_arm_status) begin
                    next_state.sp_state = timer_gate_pkg::SP_WAIT_EDGE;
                end
            end
            timer_gate_pkg::SP_WAIT_EDGE: begin
                if (!state.gate_pulse_arm_status) begin
                    next_state.sp_state = timer_gate_pkg::SP_IDLE;
                end else if (gate_rise) begin
                    next_state.sp_state = timer_gate_pkg::SP_COUNTING;
                end
            end
            timer_gate_pkg::SP_COUNTING: begin
                if (!state.gate_pulse_arm_status) begin
                    next_state.sp_state = timer_gate_pkg::SP_IDLE;
                end else if (gate_fall) begin
                    pulse_done = 1'b1;
                    next_state.sp_state = timer_gate_pkg::SP_IDLE;
                end
            end
            default: begin
                next_state.sp_state = timer_gate_pkg::SP_IDLE;
            end
        endcase

        // Level seen by the counter
        if (state.gate_single_pulse_enable) begin
            level_now = (state.sp_state == timer_gate_pkg::SP_COUNTING) && gate_level;
        end else begin
            level_now = gate_level;
        end
        next_state.gate_current_level = level_now;
        level_fall = state.gate_current_level && !level_now;

        // Hardware completion clears arm; a same-cycle write re-arm wins
        if (pulse_done) begin
            next_state.gate_pulse_arm_status = 1'b0;
        end

        // Read clears the event flag unless a new event lands now
        if (rd && (paddr == timer_gate_pkg::ADDR_IRQ_STATUS)) begin
            next_state.gate_event_flag = 1'b0;
        end
        if (level_fall) begin
            next_state.gate_event_flag = 1'b1;
        end

        if (wr) begin
            case (paddr)
                timer_gate_pkg::ADDR_GATE_CONTROL: begin
                    next_state.gate_function_enable =
                        pwdata[timer_gate_pkg::GATE_FUNCTION_ENABLE_BIT];
                    next_state.gate_polarity_select =
                        pwdata[timer_gate_pkg::GATE_POLARITY_BIT];
                    next_state.gate_toggle_enable =
                        pwdata[timer_gate_pkg::GATE_TOGGLE_BIT];
                    next_state.gate_single_pulse_enable =
                        pwdata[timer_gate_pkg::GATE_SINGLE_PULSE_BIT];
                    next_state.gate_source_select =
                        pwdata[timer_gate_pkg::GATE_SOURCE_LSB +:
                               timer_gate_pkg::GATE_SOURCE_WIDTH];
                    // Arm only sticks with single-pulse enabled
                    next_state.gate_pulse_arm_status =
                        pwdata[timer_gate_pkg::GATE_ARM_STATUS_BIT] &&
                        pwdata[timer_gate_pkg::GATE_SINGLE_PULSE_BIT];
                end
                timer_gate_pkg::ADDR_RUN_CONTROL: begin
                    next_state.timer_run_enable = pwdata[timer_gate_pkg::RUN_ENABLE_BIT];
                end
                timer_gate_pkg::ADDR_IRQ_MASK: begin
                    next_state.gate_event_mask = pwdata[timer_gate_pkg::GATE_EVENT_BIT];
                end
                default: begin
                    next_state.gate_event_mask = state.gate_event_mask;
                end
            endcase
        end

        // Gate function is ignored while the timer is stopped
        next_state.count_enable = next_state.timer_run_enable &&
            (!next_state.gate_function_enable || level_now);
        next_state.irq = next_state.gate_event_flag && next_state.gate_event_mask;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state                          <= '0;
            state.gate_function_enable     <= timer_gate_pkg::GATE_FUNCTION_ENABLE_RESET;
            state.gate_polarity_select     <= timer_gate_pkg::GATE_POLARITY_RESET;
            state.gate_toggle_enable       <= timer_gate_pkg::GATE_TOGGLE_RESET;
            state.gate_single_pulse_enable <= timer_gate_pkg::GATE_SINGLE_PULSE_RESET;
            state.gate_pulse_arm_status    <= timer_gate_pkg::GATE_ARM_STATUS_RESET;
            state.gate_source_select       <= timer_gate_pkg::GATE_SOURCE_RESET;
            state.timer_run_enable         <= timer_gate_pkg::RUN_ENABLE_RESET;
            state.gate_event_mask          <= timer_gate_pkg::IRQ_MASK_RESET;
            state.sp_state                 <= timer_gate_pkg::SP_IDLE;
        end else begin
            state <= next_state;
        end
    end

    assign pready       = state.pready;
    assign prdata       = state.prdata;
    assign pslverr      = state.pslverr;
    assign count_enable = state.count_enable;
    assign irq          = state.irq;

endmodule

// file: logic/timer_gate_pkg.sv
package timer_gate_pkg;

    // Register byte addresses
    localparam logic [11:0] ADDR_GATE_CONTROL = 12'h000;
    localparam logic [11:0] ADDR_RUN_CONTROL  = 12'h004;
    localparam logic [11:0] ADDR_IRQ_STATUS   = 12'h008;
    localparam logic [11:0] ADDR_IRQ_MASK     = 12'h00C;

    // Gate control field positions
    localparam int GATE_FUNCTION_ENABLE_BIT = 7;
    localparam int GATE_POLARITY_BIT        = 6;
    localparam int GATE_TOGGLE_BIT          = 5;
    localparam int GATE_SINGLE_PULSE_BIT    = 4;
    localparam int GATE_ARM_STATUS_BIT      = 3;
    localparam int GATE_LEVEL_BIT           = 2;
    localparam int GATE_SOURCE_LSB          = 0;
    localparam int GATE_SOURCE_WIDTH        = 2;

    // Other field positions
    localparam int RUN_ENABLE_BIT  = 0;
    localparam int GATE_EVENT_BIT  = 0;

    // Widths
    localparam int GATE_SOURCES    = 4;
    localparam int APB_ADDR_WIDTH  = 12;
    localparam int APB_DATA_WIDTH  = 32;

    // Values after reset
    localparam logic       GATE_FUNCTION_ENABLE_RESET = 1'b0;
    localparam logic       GATE_POLARITY_RESET        = 1'b0;
    localparam logic       GATE_TOGGLE_RESET          = 1'b0;
    localparam logic       GATE_SINGLE_PULSE_RESET    = 1'b0;
    localparam logic       GATE_ARM_STATUS_RESET      = 1'b0;
    localparam logic [1:0] GATE_SOURCE_RESET          = 2'h0;
    localparam logic       RUN_ENABLE_RESET           = 1'b0;
    localparam logic       IRQ_MASK_RESET             = 1'b0;

    typedef enum logic [1:0] {
        SP_IDLE,
        SP_WAIT_EDGE,
        SP_COUNTING
    } single_pulse_state_t;

endpackage

// file: logic/gate_conditioner.sv
`timescale 1ns/1ps
module gate_conditioner (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [3:0] gate_source,
    input  wire logic [1:0] source_select,
    input  wire logic       polarity_high,
    input  wire logic       toggle_enable,
    output logic            gate_level
);

    typedef struct packed {
        logic active_prev;
        logic toggle_ff;
        logic level;
    } conditioner_state_t;

    conditioner_state_t state;
    conditioner_state_t next_state;

    always_comb begin
        logic raw;
        logic active;
        raw = 1'b0;
        active = 1'b0;
        next_state = state;
        raw = gate_source[source_select];
        // Active-low gate counts while the pin is low
        active = polarity_high ? raw : ~raw;
        next_state.active_prev = active;
        if (!toggle_enable) begin
            next_state.toggle_ff = 1'b0;
        end else if (active && !state.active_prev) begin
            next_state.toggle_ff = ~state.toggle_ff;
        end
        next_state.level = toggle_enable ? next_state.toggle_ff : active;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign gate_level = state.level;

endmodule

// file: logic/level_edge_detect.sv
`timescale 1ns/1ps
module level_edge_detect (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic level,
    output logic      rise,
    output logic      fall
);

    typedef struct packed {
        logic prev;
    } edge_state_t;

    edge_state_t state;
    edge_state_t next_state;

    always_comb begin
        next_state = state;
        next_state.prev = level;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign rise = level & ~state.prev;
    assign fall = ~level & state.prev;

endmodule

// file: tb/timer_gate_chk.sv
`timescale 1ns/1ps
module timer_gate_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  gate_source,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        count_enable,
    input wire logic        irq
);
    logic [3:0] quiet;
    logic [3:0] gate_q;
    logic       mapped;
    logic       clr_op;
    assign mapped = paddr == timer_gate_pkg::ADDR_GATE_CONTROL
        || paddr == timer_gate_pkg::ADDR_RUN_CONTROL
        || paddr == timer_gate_pkg::ADDR_IRQ_STATUS || paddr == timer_gate_pkg::ADDR_IRQ_MASK;
    assign clr_op = pready && (pwrite ? paddr == timer_gate_pkg::ADDR_IRQ_MASK
        : paddr == timer_gate_pkg::ADDR_IRQ_STATUS);
    // Cycles since the last cause that may move count_enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quiet  <= 4'h0;
            gate_q <= 4'h0;
        end else begin
            gate_q <= gate_source;
            if (gate_source != gate_q || (pready && pwrite)) begin
                quiet <= 4'h0;
            end else if (quiet != 4'hF) begin
                quiet <= quiet + 4'h1;
            end
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_once: assert property (pready |=> !pready)
        else $error("pready held over one cycle");
    a_ready_phase: assert property (pready |-> psel && penable && $past(psel && penable))
        else $error("pready outside second access cycle");
    a_ready_latency: assert property ((psel && !penable) ##1 (psel && penable) |=> pready)
        else $error("pready late");
    a_error_unmapped: assert property (pready && !mapped |-> pslverr)
        else $error("no error on unmapped address");
    a_error_mapped: assert property (pready && mapped |-> !pslverr)
        else $error("error on mapped address");
    a_error_data: assert property (pready && pslverr |-> prdata == 32'h00000000)
        else $error("read data on refused access");
    a_irq_clear: assert property ($fell(irq) |-> $past(clr_op))
        else $error("irq dropped without clear");
    a_count_cause: assert property ($changed(count_enable) |-> quiet < 4'h6)
        else $error("count_enable moved without cause");
    c_read: cover property (pready && !pwrite && mapped);
    c_irq: cover property ($rose(irq));
    c_count: cover property ($rose(count_enable));
    c_refused: cover property (pready && pslverr);
endmodule
bind timer_gate_single_pulse_control timer_gate_chk timer_gate_chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .gate_source(gate_source), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .count_enable(count_enable), .irq(irq));

// file: tb/timer_gate_single_pulse_control_bench.sv
`timescale 1ns/1ps
module timer_gate_single_pulse_control_bench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0]  gate_source = 4'h0;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        count_enable;
    logic        irq;
    logic [31:0] seed = 32'h00001581;
    logic [31:0] rdat;
    logic [31:0] v;
    logic        rerr;
    logic [31:0] m_gcon = 32'h00000000;
    int          m_cnt = 0;
    int          n_errors = 0;
    int          n_compared = 0;
    always #20 pclk = ~pclk;
    timer_gate_single_pulse_control timer_gate_single_pulse_control_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .gate_source(gate_source), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .count_enable(count_enable), .irq(irq));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Model view of the gate register, level bit derived from the pin
    function automatic logic [31:0] exp_gcon();
        logic lvl;
        lvl = gate_source[m_gcon[1:0]] ~^ m_gcon[6];
        if (m_gcon[4]) lvl = lvl && (m_cnt != 0);
        return m_gcon | {29'h0, lvl, 2'h0};
    endfunction
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge pclk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 20) begin
            n_errors++;
            summarize();
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h00000000);
        check(what, rdat, exp);
        check("pslverr", {31'h0, rerr}, 32'h00000000);
    endtask
    // Arm written with single-pulse off is dropped by the device
    task automatic wr_gcon(input logic [31:0] d);
        apb(1'b1, timer_gate_pkg::ADDR_GATE_CONTROL, d);
        m_gcon = d[4] ? d : d & ~32'h00000008;
    endtask
    task automatic wait_for(input logic which, input logic lv);
        int i;
        for (i = 0; i < 20 && (which ? irq : count_enable) !== lv; i++) @(posedge pclk);
        check(which ? "irq" : "count_enable", {31'h0, which ? irq : count_enable}, {31'h0, lv});
        if (i == 20) summarize();
    endtask
    task automatic gate(input logic [3:0] g);
        @(posedge pclk);
        gate_source <= g;
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(timer_gate_pkg::ADDR_GATE_CONTROL, exp_gcon(), "gate_control");
        for (int i = 1; i < 4; i++) rd(12'(i * 4), 32'h00000000, "reset value");
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            v = xs();
            gate_source <= v[11:8];
            wr_gcon(v & 32'h000000CB);
            rd(timer_gate_pkg::ADDR_GATE_CONTROL, exp_gcon(), "gate_control");
            apb(v[12], 12'h010 + 12'(i * 4), xs());
            check("unmapped pslverr", {31'h0, rerr}, 32'h00000001);
            check("unmapped prdata", rdat, 32'h00000000);
        end
        $display("test fields done");
        wr_gcon(32'h00000040);
        gate(4'h0);
        apb(1'b0, timer_gate_pkg::ADDR_IRQ_STATUS, 32'h00000000);
        rd(timer_gate_pkg::ADDR_IRQ_STATUS, 32'h00000000, "flag cleared");
        apb(1'b1, timer_gate_pkg::ADDR_RUN_CONTROL, 32'h00000001);
        wr_gcon(32'h000000D0);
        wait_for(1'b0, 1'b0);
        wr_gcon(32'h000000D8);
        rd(timer_gate_pkg::ADDR_GATE_CONTROL, exp_gcon(), "armed");
        gate(4'h1);
        m_cnt = 1;
        wait_for(1'b0, 1'b1);
        rd(timer_gate_pkg::ADDR_GATE_CONTROL, exp_gcon(), "counting");
        gate(4'h0);
        m_cnt = 0;
        m_gcon = 32'h000000D0;
        wait_for(1'b0, 1'b0);
        rd(timer_gate_pkg::ADDR_GATE_CONTROL, exp_gcon(), "done");
        check("masked irq", {31'h0, irq}, 32'h00000000);
        rd(timer_gate_pkg::ADDR_IRQ_STATUS, 32'h00000001, "flag set");
        gate(4'h1);
        repeat (4) @(posedge pclk);
        check("unarmed count", {31'h0, count_enable}, 32'h00000000);
        gate(4'h0);
        rd(timer_gate_pkg::ADDR_IRQ_STATUS, 32'h00000000, "flag read clear");
        $display("test single pulse done");
        apb(1'b1, timer_gate_pkg::ADDR_IRQ_MASK, 32'h00000001);
        wr_gcon(32'h000000D8);
        wr_gcon(32'h000000C8);
        rd(timer_gate_pkg::ADDR_GATE_CONTROL, exp_gcon(), "abort");
        gate(4'h1);
        wait_for(1'b0, 1'b1);
        gate(4'h0);
        wait_for(1'b1, 1'b1);
        rd(timer_gate_pkg::ADDR_IRQ_STATUS, 32'h00000001, "flag");
        wait_for(1'b1, 1'b0);
        wr_gcon(32'h00000040);
        wait_for(1'b0, 1'b1);
        apb(1'b1, timer_gate_pkg::ADDR_RUN_CONTROL, 32'h00000000);
        wait_for(1'b0, 1'b0);
        // Toggle mode: level flips on each active rising edge
        wr_gcon(32'h00000060);
        gate(4'h1);
        gate(4'h0);
        repeat (3) @(posedge pclk);
        rd(timer_gate_pkg::ADDR_GATE_CONTROL, 32'h00000064, "toggle high");
        gate(4'h1);
        gate(4'h0);
        repeat (3) @(posedge pclk);
        rd(timer_gate_pkg::ADDR_GATE_CONTROL, 32'h00000060, "toggle low");
        $display("test abort irq done");
        summarize();
    end
endmodule
